// *** rtl/spi_serial_unit.sv ***
`timescale 1ns/1ps
`include "spi_unit_defs.svh"

// Behaviour
// - Fault arises for a phase-1 slave whose clock is off idle at release.
// - Unit A under fault never receives and drops the first output bit.
// - Unit B under fault receives fine but repeats its first output byte.
// - Master byte written while enable input inactive may go out corrupt.
// - With the enable pin as output, master bytes always go out correctly.
module spi_serial_unit
    import spi_unit_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Avalon-MM slave
    input wire logic [4:0] address_i,
    input wire logic [3:0] byteenable_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Serial link pins
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic enable_pin_i,
    output logic enable_pin_o,
    output logic enable_pin_oe_n_o,
    // Interrupt
    output logic irq_o
);
    shift_if sh ();

    logic [3:0] lvl;
    logic sclk_lvl, mosi_lvl, miso_lvl, ste_lvl;

    // Bus group
    logic wait_r, wait_nxt, irq_r, irq_nxt, tx_full_r, tx_full_nxt;
    logic [31:0] rdata_r, rdata_nxt, rd_val;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [3:0] flags_r, flags_nxt, mask_r, mask_nxt, flg_set, flg_clr;
    byte_t txbuf_r, txbuf_nxt, rxbuf_r, rxbuf_nxt;
    logic wr_tx;

    // Link group
    master_state_t mstate_r, mstate_nxt;
    logic [7:0] div_r, div_nxt;
    logic [3:0] tog_r, tog_nxt;
    logic sck_r, sck_nxt, hold_prev_r, hold_prev_nxt;
    logic fault_r, fault_nxt, dup_r, dup_nxt, rep_r, rep_nxt;
    logic armed_r, armed_nxt, sclk_prev_r, sclk_prev_nxt;
    logic stale_r, stale_nxt, loaded_r, loaded_nxt;
    byte_t last_r, last_nxt;
    logic mosi_r, mosi_nxt, miso_r, miso_nxt, ste_r, ste_nxt;
    logic sck_oe_n_r, sck_oe_n_nxt, mosi_oe_n_r, mosi_oe_n_nxt;
    logic miso_oe_n_r, miso_oe_n_nxt, ste_oe_n_r, ste_oe_n_nxt;
    logic ev_load, ev_rx, ev_abort, ev_fault;

    // Control fields
    logic hold, cpha, cpol, master, pindir, unit_b, emul, ste_ok, fault_a;
    logic [7:0] div;

    pin_sync u_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .pin_i({enable_pin_i, miso_i, mosi_i, sclk_i}),
        .level_o(lvl)
    );

    shift_engine u_eng (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .sh(sh.eng)
    );

    // Field decode and synchronised pin levels
    always_comb begin
        {ste_lvl, miso_lvl, mosi_lvl, sclk_lvl} = lvl;
        hold = ctrl_r[`CTRL_HOLD];
        cpha = ctrl_r[`CTRL_PHASE];
        cpol = ctrl_r[`CTRL_POL];
        master = ctrl_r[`CTRL_MASTER];
        pindir = ctrl_r[`CTRL_PINDIR];
        unit_b = ctrl_r[`CTRL_UNIT_B];
        emul = ctrl_r[`CTRL_EMUL];
        div = ctrl_r[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
        // Input mode lets a low enable pin grant the bus to this master
        ste_ok = pindir | ~ste_lvl;
        fault_a = fault_r & ~unit_b;
        wr_tx = write_i && !wait_r && address_i == `REG_TXBUF
            && byteenable_i[0];
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (address_i)
            `REG_CTRL: rd_val = {16'h0000, ctrl_r};
            `REG_FLAGS: rd_val = {28'h000_0000, flags_r};
            `REG_MASK: rd_val = {28'h000_0000, mask_r};
            `REG_TXBUF: rd_val = {24'h00_0000, txbuf_r};
            `REG_RXBUF: rd_val = {24'h00_0000, rxbuf_r};
            `REG_STAT: rd_val = {24'h00_0000, tx_full_r, mstate_r,
                sh.busy, armed_r, fault_r, ste_lvl, sclk_lvl, stale_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Bus slave: one wait cycle, then the access lands as waitrequest drops
    always_comb begin
        wait_nxt = wait_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        txbuf_nxt = txbuf_r;
        rxbuf_nxt = rxbuf_r;
        tx_full_nxt = tx_full_r & ~ev_load;
        flg_clr = 4'h0;
        flg_set = 4'h0;
        flg_set[`FLG_RX] = ev_rx;
        flg_set[`FLG_TX] = ev_load;
        flg_set[`FLG_ABORT] = ev_abort;
        flg_set[`FLG_FAULT] = ev_fault;
        if (wait_r) begin
            if (read_i || write_i) begin
                wait_nxt = 1'b0;
                rdata_nxt = read_i ? rd_val : 32'h0000_0000;
            end
        end else begin
            wait_nxt = 1'b1;
            if (write_i) begin
                unique case (address_i)
                    `REG_CTRL: begin
                        if (byteenable_i[0]) begin
                            ctrl_nxt[7:0] = writedata_i[7:0];
                        end
                        if (byteenable_i[1]) begin
                            ctrl_nxt[15:8] = writedata_i[15:8];
                        end
                    end
                    `REG_FLAGS: begin
                        if (byteenable_i[0]) begin
                            flg_clr = writedata_i[3:0];
                        end
                    end
                    `REG_MASK: begin
                        if (byteenable_i[0]) begin
                            mask_nxt = writedata_i[3:0];
                        end
                    end
                    `REG_TXBUF: begin
                        if (byteenable_i[0]) begin
                            txbuf_nxt = writedata_i[7:0];
                            tx_full_nxt = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // A received byte replaces the buffer; under unit A fault none comes
        if (ev_rx) begin
            rxbuf_nxt = sh.rx_data;
        end
        // Set beats clear when both land in one cycle
        flags_nxt = (flags_r & ~flg_clr) | flg_set;
        irq_nxt = |(flags_r & mask_r);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            ctrl_r <= `CTRL_RST;
            flags_r <= `FLG_RST;
            mask_r <= `FLG_RST;
            txbuf_r <= 8'h00;
            rxbuf_r <= 8'h00;
            tx_full_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
            txbuf_r <= txbuf_nxt;
            rxbuf_r <= rxbuf_nxt;
            tx_full_r <= tx_full_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Link side: master framing, slave edge finding and the fault model
    always_comb begin
        mstate_nxt = mstate_r;
        div_nxt = div_r;
        tog_nxt = tog_r;
        sck_nxt = sck_r;
        hold_prev_nxt = hold;
        fault_nxt = fault_r;
        dup_nxt = dup_r;
        rep_nxt = rep_r;
        armed_nxt = armed_r;
        sclk_prev_nxt = sclk_lvl;
        stale_nxt = stale_r;
        loaded_nxt = loaded_r & ~sh.byte_done;
        last_nxt = last_r;
        ev_load = 1'b0;
        ev_abort = 1'b0;
        ev_fault = 1'b0;
        sh.load = 1'b0;
        sh.clear = 1'b0;
        sh.lead = 1'b0;
        sh.trail = 1'b0;
        sh.cpha = cpha;
        sh.sin = master ? miso_lvl : mosi_lvl;
        sh.tx_data = rep_r ? last_r : txbuf_r;
        // Unit A fault loses the first bit; so may a blocked-time write
        sh.drop_first = master ? (stale_r & emul) : fault_a;
        ev_rx = sh.byte_done & ~fault_a;
        if (hold) begin
            sh.clear = 1'b1;
            mstate_nxt = M_IDLE;
            sck_nxt = cpol;
            fault_nxt = 1'b0;
            dup_nxt = 1'b0;
            rep_nxt = 1'b0;
            armed_nxt = 1'b0;
            stale_nxt = 1'b0;
            loaded_nxt = 1'b0;
        end else if (master) begin
            // Only meaningful when the pin is an input gating this master
            if (wr_tx && !pindir && ste_lvl) begin
                stale_nxt = 1'b1;
            end
            unique case (mstate_r)
                M_IDLE: begin
                    sck_nxt = cpol;
                    if (tx_full_r && ste_ok) begin
                        sh.load = 1'b1;
                        ev_load = 1'b1;
                        mstate_nxt = M_RUN;
                        div_nxt = `DIV_ZERO;
                        tog_nxt = `TOG_FIRST;
                    end
                end
                M_RUN: begin
                    if (!ste_ok) begin
                        // Byte is lost; software must write it again
                        sh.clear = 1'b1;
                        ev_abort = 1'b1;
                        mstate_nxt = M_IDLE;
                        sck_nxt = cpol;
                        stale_nxt = 1'b0;
                    end else if (div_r == div) begin
                        div_nxt = `DIV_ZERO;
                        sck_nxt = ~sck_r;
                        sh.lead = (sck_r == cpol);
                        sh.trail = (sck_r != cpol);
                        tog_nxt = tog_r + `TOG_STEP;
                        if (tog_r == `TOG_LAST) begin
                            mstate_nxt = M_IDLE;
                            stale_nxt = 1'b0;
                        end
                    end else begin
                        div_nxt = div_r + `DIV_STEP;
                    end
                end
                default: begin
                    mstate_nxt = M_IDLE;
                end
            endcase
        end else begin
            // First cycle after release: judge the clock level seen then
            if (hold_prev_r) begin
                fault_nxt = emul && cpha && (sclk_lvl != cpol);
                dup_nxt = fault_nxt & unit_b;
                ev_fault = fault_nxt;
            end
            // Edges count only after the clock was seen idle once or a fault was flagged
            armed_nxt = armed_r | (sclk_lvl == cpol) | fault_r;
            if (ste_lvl) begin
                sh.clear = 1'b1;
                loaded_nxt = loaded_r & ~sh.busy; // Whole preload kept
            end else if (armed_r && sclk_lvl != sclk_prev_r) begin
                sh.lead = (sclk_lvl != cpol);
                sh.trail = (sclk_lvl == cpol);
            end else if (!loaded_r && !sh.busy && (tx_full_r || rep_r)) begin
                sh.load = 1'b1;
                loaded_nxt = 1'b1;
                rep_nxt = 1'b0;
                ev_load = ~rep_r;
            end
            // Unit B fault sends its first byte a second time
            if (sh.byte_done && dup_r) begin
                dup_nxt = 1'b0;
                rep_nxt = 1'b1;
            end
        end
        if (sh.load) begin
            last_nxt = sh.tx_data;
        end
        // Pin drivers, all registered
        mosi_nxt = sh.sout;
        miso_nxt = sh.sout;
        ste_nxt = (mstate_r != M_RUN);
        sck_oe_n_nxt = ~master;
        mosi_oe_n_nxt = ~master;
        miso_oe_n_nxt = master | hold | ste_lvl;
        ste_oe_n_nxt = ~(master & pindir);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mstate_r <= M_IDLE;
            div_r <= `DIV_ZERO;
            tog_r <= `TOG_FIRST;
            sck_r <= 1'b0;
            hold_prev_r <= 1'b1;
            fault_r <= 1'b0;
            dup_r <= 1'b0;
            rep_r <= 1'b0;
            armed_r <= 1'b0;
            sclk_prev_r <= 1'b0;
            stale_r <= 1'b0;
            loaded_r <= 1'b0;
            last_r <= 8'h00;
            mosi_r <= 1'b0;
            miso_r <= 1'b0;
            ste_r <= 1'b1;
            sck_oe_n_r <= 1'b1;
            mosi_oe_n_r <= 1'b1;
            miso_oe_n_r <= 1'b1;
            ste_oe_n_r <= 1'b1;
        end else begin
            mstate_r <= mstate_nxt;
            div_r <= div_nxt;
            tog_r <= tog_nxt;
            sck_r <= sck_nxt;
            hold_prev_r <= hold_prev_nxt;
            fault_r <= fault_nxt;
            dup_r <= dup_nxt;
            rep_r <= rep_nxt;
            armed_r <= armed_nxt;
            sclk_prev_r <= sclk_prev_nxt;
            stale_r <= stale_nxt;
            loaded_r <= loaded_nxt;
            last_r <= last_nxt;
            mosi_r <= mosi_nxt;
            miso_r <= miso_nxt;
            ste_r <= ste_nxt;
            sck_oe_n_r <= sck_oe_n_nxt;
            mosi_oe_n_r <= mosi_oe_n_nxt;
            miso_oe_n_r <= miso_oe_n_nxt;
            ste_oe_n_r <= ste_oe_n_nxt;
        end
    end

    assign readdata_o = rdata_r;
    assign waitrequest_o = wait_r;
    assign irq_o = irq_r;
    assign sclk_o = sck_r;
    assign sclk_oe_n_o = sck_oe_n_r;
    assign mosi_o = mosi_r;
    assign mosi_oe_n_o = mosi_oe_n_r;
    assign miso_o = miso_r;
    assign miso_oe_n_o = miso_oe_n_r;
    assign enable_pin_o = ste_r;
    assign enable_pin_oe_n_o = ste_oe_n_r;
endmodule

// *** common/spi_unit_defs.svh ***
`ifndef SPI_UNIT_DEFS_SVH
`define SPI_UNIT_DEFS_SVH

// Register byte offsets
`define REG_CTRL 5'h00
`define REG_FLAGS 5'h04
`define REG_MASK 5'h08
`define REG_TXBUF 5'h0C
`define REG_RXBUF 5'h10
`define REG_STAT 5'h14

// Control word bits
`define CTRL_HOLD 0
`define CTRL_PHASE 1
`define CTRL_POL 2
`define CTRL_MASTER 3
`define CTRL_PINDIR 4
`define CTRL_UNIT_B 5
`define CTRL_EMUL 6
`define CTRL_DIV_LSB 8
`define CTRL_DIV_MSB 15
`define CTRL_RST 16'h0441

// Flag bits, shared by status and mask
`define FLG_RX 0
`define FLG_TX 1
`define FLG_ABORT 2
`define FLG_FAULT 3
`define FLG_RST 4'h0

// Shift and framing counts
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define BIT_STEP 3'h1
`define TOG_FIRST 4'h0
`define TOG_LAST 4'hF
`define TOG_STEP 4'h1
`define DIV_STEP 8'h01
`define DIV_ZERO 8'h00

// Pin synchroniser reset levels: enable pin idle high, others low
`define PIN_RST 4'h8

`endif

// *** common/spi_unit_pkg.sv ***
package spi_unit_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic {
        M_IDLE = 1'b0,
        M_RUN = 1'b1
    } master_state_t;

endpackage

// *** common/shift_if.sv ***
`timescale 1ns/1ps

interface shift_if;
    import spi_unit_pkg::*;
    logic load;
    logic clear;
    logic lead;
    logic trail;
    logic cpha;
    logic drop_first;
    logic sin;
    byte_t tx_data;
    logic sout;
    byte_t rx_data;
    logic byte_done;
    logic busy;

    modport eng (
        input load, clear, lead, trail, cpha, drop_first, sin, tx_data,
        output sout, rx_data, byte_done, busy
    );
    modport ctl (
        output load, clear, lead, trail, cpha, drop_first, sin, tx_data,
        input sout, rx_data, byte_done, busy
    );
endinterface

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`include "spi_unit_defs.svh"

module pin_sync
    import spi_unit_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Raw pins and filtered levels
    input wire logic [3:0] pin_i,
    output logic [3:0] level_o
);
    logic [3:0] s1_r, s2_r, s3_r, lvl_r;
    logic [3:0] lvl_nxt;

    // A level counts only once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_bit
            always_comb begin
                lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
            end
        end
    endgenerate

    // Three stages; the first feeds only the second
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_r <= `PIN_RST;
            s2_r <= `PIN_RST;
            s3_r <= `PIN_RST;
            lvl_r <= `PIN_RST;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign level_o = lvl_r;
endmodule

// *** rtl/shift_engine.sv ***
`timescale 1ns/1ps
`include "spi_unit_defs.svh"

module shift_engine
    import spi_unit_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Control side
    shift_if.eng sh
);
    byte_t sh_r, sh_nxt, rx_r, rx_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic shift_edge, cap_edge;

    // Phase 1 shifts on the leading edge, phase 0 on the trailing one
    always_comb begin
        shift_edge = sh.cpha ? sh.lead : sh.trail;
        cap_edge = sh.cpha ? sh.trail : sh.lead;
        sh_nxt = sh_r;
        rx_nxt = rx_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (sh.clear) begin
            cnt_nxt = `BIT_FIRST;
        end else if (sh.load) begin
            // A dropped first bit leaves the byte one place early
            sh_nxt = sh.drop_first ? {sh.tx_data[6:0], 1'b0} : sh.tx_data;
            cnt_nxt = `BIT_FIRST;
        end else begin
            // No shift before the first capture: bit 7 is already out
            if (shift_edge && cnt_r != `BIT_FIRST) begin
                sh_nxt = {sh_r[6:0], 1'b0};
            end
            if (cap_edge) begin
                rx_nxt = {rx_r[6:0], sh.sin};
                cnt_nxt = cnt_r + `BIT_STEP;
                done_nxt = (cnt_r == `BIT_LAST);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_r <= 8'h00;
            rx_r <= 8'h00;
            cnt_r <= `BIT_FIRST;
            done_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            rx_r <= rx_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign sh.sout = sh_r[7];
    assign sh.rx_data = rx_r;
    assign sh.byte_done = done_r;
    assign sh.busy = (cnt_r != `BIT_FIRST);
endmodule

// *** tb/spi_unit_assertions.sv ***
`timescale 1ns/1ps

module spi_unit_assertions (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Register bus
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    // Link pins and interrupt
    input wire logic sclk_o,
    input wire logic sclk_oe_n_o,
    input wire logic mosi_oe_n_o,
    input wire logic miso_o,
    input wire logic miso_oe_n_o,
    input wire logic enable_pin_o,
    input wire logic enable_pin_oe_n_o,
    input wire logic irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    // Bus answers after one wait cycle, then idles again
    chk_wait_single: assert property ((read_i || write_i) && waitrequest_o
        |=> !waitrequest_o ##1 waitrequest_o) else $error("wait length");
    chk_write_zero: assert property (write_i && waitrequest_o
        |=> readdata_o == 32'h0) else $error("write data not zero");
    chk_unmapped_zero: assert property (read_i && address_i > 5'h14
        && waitrequest_o |=> readdata_o == 32'h0) else $error("unmapped");
    chk_reset_quiet: assert property ($rose(arst_n_i)
        |-> waitrequest_o && !irq_o && enable_pin_o) else $error("reset");
    // Master clock halves last at least five cycles
    chk_half_period: assert property (!sclk_oe_n_o && $changed(sclk_o)
        |=> $stable(sclk_o) [*4]) else $error("short clock half");
    chk_frame_drive: assert property (!enable_pin_oe_n_o && !enable_pin_o
        |-> !sclk_oe_n_o && !mosi_oe_n_o) else $error("frame not driven");
    chk_miso_hold: assert property (!miso_oe_n_o && $changed(miso_o)
        |=> $stable(miso_o) [*3]) else $error("slave bit too short");
    chk_one_driver: assert property (!sclk_oe_n_o |-> miso_oe_n_o)
        else $error("master and slave drive together");

    cover property ($rose(irq_o));
    cover property ($fell(enable_pin_o));
    cover property ($fell(miso_oe_n_o));
endmodule

bind spi_serial_unit spi_unit_assertions chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .sclk_o(sclk_o),
    .sclk_oe_n_o(sclk_oe_n_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o), .enable_pin_o(enable_pin_o),
    .enable_pin_oe_n_o(enable_pin_oe_n_o), .irq_o(irq_o));

// *** tb/spi_far_end.sv ***
`timescale 1ns/1ps

module spi_far_end
    import spi_unit_pkg::*;
(
    // Pins toward the unit
    output logic sclk_o,
    output logic mosi_o,
    output logic ss_n_o,
    output logic miso_o,
    // Resolved link lines
    input wire logic dsclk_i,
    input wire logic dmosi_i,
    input wire logic dmiso_i
);
    byte_t cap;
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
        cap = 8'h00;
    end
    // Capture what a master sends, MSB first on rising clock
    always @(posedge dsclk_i) cap <= {cap[6:0], dmosi_i};
    // Answer line flips each bit so stale data never looks valid
    assign miso_o = ~cap[0];

    task park(input logic lvl);
        sclk_o = lvl;
    endtask
    task select(input logic on);
        ss_n_o = !on;
    endtask
    // One byte, 400 ns clock only inside the frame; phase 1 stretches low
    task frame(input byte_t d, input logic ph, output byte_t r);
        ss_n_o = 1'b0;
        #1000;
        for (int i = 7; i >= 0; i--) begin
            if (!ph) mosi_o = d[i];
            #200 sclk_o = 1'b1;
            if (ph) mosi_o = d[i];
            #190 if (!ph) r[i] = dmiso_i;
            #10 sclk_o = 1'b0;
            if (ph) begin
                #190 r[i] = dmiso_i;
                #10;
            end
        end
        #1000 ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask
endmodule

// *** tb/test_spi_phase_and_enable_pin_faults.sv ***
`timescale 1ns/1ps
`include "spi_unit_defs.svh"

module test_spi_phase_and_enable_pin_faults
    import spi_unit_pkg::*;
;
    logic mclk_i = 1'b0;
    logic arst_n_i, read_i, write_i, waitrequest_o, irq_o;
    logic [4:0] address_i;
    logic [3:0] byteenable_i;
    logic [31:0] writedata_i, readdata_o, q;
    logic sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
    logic enable_pin_o, enable_pin_oe_n_o;
    wire f_sclk, f_mosi, f_ss_n, f_miso;
    int num_errors = 0;
    int tests_run = 0;
    byte_t r;
    // Each pin carries whoever has its enable low
    wire sclk_w = sclk_oe_n_o ? f_sclk : sclk_o;
    wire mosi_w = mosi_oe_n_o ? f_mosi : mosi_o;
    wire miso_w = miso_oe_n_o ? f_miso : miso_o;
    wire en_w = enable_pin_oe_n_o ? f_ss_n : enable_pin_o;

    always #25 mclk_i = ~mclk_i;

    spi_serial_unit dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .address_i(address_i), .byteenable_i(byteenable_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
        .enable_pin_i(en_w), .enable_pin_o(enable_pin_o),
        .enable_pin_oe_n_o(enable_pin_oe_n_o), .irq_o(irq_o));
    spi_far_end far (.sclk_o(f_sclk), .mosi_o(f_mosi), .ss_n_o(f_ss_n),
        .miso_o(f_miso), .dsclk_i(sclk_w), .dmosi_i(mosi_w),
        .dmiso_i(miso_w));

    task end_of_test;
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        address_i <= a;
        write_i <= w;
        read_i <= !w;
        writedata_i <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 20);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
    endtask
    // Poll until the master is done and its buffer is empty
    task wait_idle;
        int k;
        k = 0;
        do begin
            bus(1'b0, `REG_STAT, 32'h0);
            k++;
        end while (q[7:6] !== 2'b00 && k < 200);
        if (k >= 200) begin
            num_errors++;
            end_of_test();
        end
    endtask
    // Hold, clear flags, park the clock at lvl, then release as slave
    task slave(input logic [31:0] c, input logic lvl);
        bus(1'b1, `REG_CTRL, c | 32'h1);
        bus(1'b1, `REG_FLAGS, 32'hF);
        far.park(lvl);
        repeat (8) @(posedge mclk_i);
        bus(1'b1, `REG_CTRL, c);
        repeat (8) @(posedge mclk_i);
        far.park(1'b0);
    endtask
    task xch(input byte_t t, input byte_t s, input logic ph);
        bus(1'b1, `REG_TXBUF, {24'h0, t});
        repeat (10) @(posedge mclk_i);
        far.frame(s, ph, r);
        repeat (10) @(posedge mclk_i);
    endtask
    task irq_is(input logic e);
        repeat (3) @(posedge mclk_i);
        chk(irq_o, e);
    endtask

    initial begin
        arst_n_i = 1'b0;
        read_i = 1'b0;
        write_i = 1'b0;
        address_i = 5'h00;
        byteenable_i = 4'h3;
        writedata_i = 32'h0;
        repeat (20) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        byteenable_i <= 4'h1;
        bus(1'b1, `REG_CTRL, 32'hFF41);
        byteenable_i <= 4'h3;
        bus(1'b0, `REG_CTRL, 32'h0);
        chk(q, 32'h0441);
        bus(1'b0, 5'h1C, 32'h0);
        chk(q, 32'h0);
        // Phase 0 slave exchanges cleanly
        slave(32'h0440, 1'b0);
        xch(8'hA5, 8'h3C, 1'b0);
        chk(r, 8'hA5);
        bus(1'b0, `REG_RXBUF, 32'h0);
        chk(q, 32'h3C);
        // Phase 1 with the clock parked at idle before release
        slave(32'h0442, 1'b0);
        xch(8'h96, 8'h69, 1'b1);
        chk(r, 8'h96);
        bus(1'b0, `REG_RXBUF, 32'h0);
        chk(q, 32'h69);
        // Unit A released with the clock off idle
        bus(1'b1, `REG_MASK, 32'h8);
        slave(32'h0442, 1'b1);
        irq_is(1'b1);
        bus(1'b1, `REG_MASK, 32'h0);
        irq_is(1'b0);
        xch(8'hA5, 8'h3C, 1'b1);
        chk({1'b0, r[7:1]}, 8'h25);
        bus(1'b0, `REG_FLAGS, 32'h0);
        chk(q[3:0], 4'hA);
        bus(1'b0, `REG_RXBUF, 32'h0);
        chk(q, 32'h69);
        // Set and clear hold, then the resend works
        slave(32'h0442, 1'b0);
        xch(8'hA5, 8'h3C, 1'b1);
        chk(r, 8'hA5);
        bus(1'b0, `REG_RXBUF, 32'h0);
        chk(q, 32'h3C);
        // Unit B receives but repeats its first byte
        slave(32'h0462, 1'b1);
        xch(8'h5A, 8'hC3, 1'b1);
        chk(r, 8'h5A);
        bus(1'b0, `REG_RXBUF, 32'h0);
        chk(q, 32'hC3);
        xch(8'h69, 8'h3C, 1'b1);
        chk(r, 8'h5A);
        // Master in conflict mode, loaded while the grant is inactive
        far.select(1'b0);
        bus(1'b1, `REG_CTRL, 32'h0449);
        bus(1'b1, `REG_FLAGS, 32'hF);
        bus(1'b1, `REG_CTRL, 32'h0448);
        bus(1'b1, `REG_TXBUF, 32'hC3);
        bus(1'b0, `REG_STAT, 32'h0);
        chk(q[0], 1'b1);
        far.select(1'b1);
        wait_idle();
        chk({1'b0, far.cap[7:1]}, 8'h43);
        bus(1'b1, `REG_TXBUF, 32'h96);
        wait_idle();
        chk(far.cap, 8'h96);
        // Abort mid frame, then reload once the grant returns
        bus(1'b1, `REG_MASK, 32'h4);
        bus(1'b1, `REG_TXBUF, 32'h3C);
        repeat (30) @(posedge mclk_i);
        far.select(1'b0);
        repeat (10) @(posedge mclk_i);
        bus(1'b0, `REG_FLAGS, 32'h0);
        chk(q[2], 1'b1);
        irq_is(1'b1);
        far.select(1'b1);
        bus(1'b1, `REG_FLAGS, 32'hF);
        irq_is(1'b0);
        bus(1'b1, `REG_TXBUF, 32'h3C);
        wait_idle();
        chk(far.cap, 8'h3C);
        // Enable pin as output: the grant input no longer matters
        far.select(1'b0);
        bus(1'b1, `REG_CTRL, 32'h0459);
        bus(1'b1, `REG_CTRL, 32'h0458);
        bus(1'b1, `REG_TXBUF, 32'hA5);
        wait_idle();
        chk(far.cap, 8'hA5);
        bus(1'b0, `REG_STAT, 32'h0);
        chk(q[0], 1'b0);
        end_of_test();
    end
endmodule
